// *** dv/vfb_host_model.sv ***
// host model: drives the register port of the line timing block
// assumes the bench owns clock enable and calls these tasks by path
module vfb_host_model (
    input  wire logic       i_clk,    // system clock
    input  wire logic [7:0] i_rdata,  // register read data
    output logic            o_we,     // write strobe
    output logic            o_re,     // read strobe
    output logic      [7:0] o_addr,   // subaddress
    output logic      [7:0] o_wdata   // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port at time zero
    initial
    begin
        o_we    = 1'b0;
        o_re    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end

    // one write; released lines show the inverse value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_we    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d & 8'hdf;
        @(posedge i_clk);
        o_we    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask

    // one read; data is taken once the registered answer settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_re   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_re   <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clk);
        #1;
        d = i_rdata;
    endtask
endmodule

// *** dv/vfb_line_timing_test.sv ***
// self-checking bench: register port and v/f edge placement
// assumes the host model owns the register port signals
module vfb_line_timing_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst, en, strt, roll, odd, s625;
    logic       we, re, v, f;
    logic [7:0] addr, wdata, rdata, rv;
    logic [5:0] cnt;
    int         miscompares, n_compared;

    vfb_line_timing vfb_line_timing_inst (
        .I_MCLK(clk), .I_SYS_RST(rst), .I_CLK_EN(en),
        .I_LINE_STRT(strt), .I_CNT_ROLL(roll), .I_FIELD_ODD(odd),
        .I_STD_625(s625), .I_REG_WE(we), .I_REG_RE(re),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_V_BIT(v), .O_F_BIT(f), .O_LINE_CNT(cnt));

    vfb_host_model vfb_host_model_inst (
        .i_clk(clk), .i_rdata(rdata), .o_we(we), .o_re(re),
        .o_addr(addr), .o_wdata(wdata));

    // 50 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    // one line: pulse, then wait for the compare edge to land
    task automatic line(input logic r);
        @(posedge clk);
        roll <= r;
        strt <= ~r;
        @(posedge clk);
        roll <= 1'b0;
        strt <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // program both sets, run two fields, check edges of the second
    task automatic field(input logic s, input logic o, input logic d);
        logic [4:0] act[3];
        logic [4:0] oth[3];
        logic [1:0] dl;
        logic [7:0] ba, bo;
        logic       pv, pf;
        int         rise, fall, tog;
        act = '{5'd8, 5'd3, 5'd5};
        oth = '{5'd10, 5'd12, 5'd14};
        dl = o ? {d, ~d} : {~d, d};
        ba = s ? vfb_pkg::OFS_PAL_VBLANK_BEGIN_LINE : vfb_pkg::OFS_N_VBEGIN;
        bo = s ? vfb_pkg::OFS_N_VBEGIN : vfb_pkg::OFS_PAL_VBLANK_BEGIN_LINE;
        s625 <= s;
        odd  <= o;
        for (int i = 0; i < 3; i++)
        begin
            vfb_host_model_inst.wr(ba + i[7:0], {dl, 1'b0, act[i]});
            vfb_host_model_inst.wr(bo + i[7:0], {3'b000, oth[i]});
        end
        for (int p = 0; p < 2; p++)
        begin
            rise = -1;
            fall = -1;
            tog  = -1;
            for (int k = 0; k < 14; k++)
            begin
                pv = v;
                pf = f;
                line(k == 0);
                chk({2'b00, cnt}, k[7:0], "line count");
                if (pv === 1'b0 && v === 1'b1 && rise < 0)
                    rise = k;
                if (pv === 1'b1 && v === 1'b0 && fall < 0)
                    fall = k;
                if (pf !== f && tog < 0)
                    tog = k;
            end
        end
        chk(rise[7:0], 8'd8 + d, "v rise");
        chk(fall[7:0], 8'd3 + d, "v fall");
        chk(tog[7:0], 8'd5 + d, "f toggle");
        $display("field test std625=%b odd=%b delay=%b done", s, o, d);
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (50000) @(posedge clk);
        miscompares++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

    // main sequence
    initial
    begin
        rst = 1'b1;
        en = 1'b1;
        strt = 1'b0;
        roll = 1'b0;
        odd = 1'b0;
        s625 = 1'b0;
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            vfb_host_model_inst.rd(vfb_pkg::OFS_N_VBEGIN + i[7:0], rv);
            chk(rv, vfb_pkg::RST_ALL[i*8 +: 8], "reset value");
        end
        vfb_host_model_inst.wr(8'heb, 8'h5a);
        vfb_host_model_inst.rd(8'heb, rv);
        chk(rv, 8'h00, "unmapped high");
        vfb_host_model_inst.rd(8'he4, rv);
        chk(rv, 8'h00, "unmapped low");
        vfb_host_model_inst.wr(vfb_pkg::OFS_PAL_VBLANK_END_LINE, 8'hc7);
        en <= 1'b0;
        vfb_host_model_inst.wr(vfb_pkg::OFS_PAL_VBLANK_END_LINE, 8'h01);
        en <= 1'b1;
        vfb_host_model_inst.rd(vfb_pkg::OFS_PAL_VBLANK_END_LINE, rv);
        chk(rv, 8'hc7, "write with enable low");
        $display("register test done");
        for (int c = 0; c < 8; c++)
            field(c[2], c[1], c[0]);
        end_sim();
    end
endmodule

// *** hdl/vfb_line_timing.sv ***
// v and f bit placement for the bt.656 output of the decoder
// assumes line start, rollover and field parity come from the core clock
// Notes on behaviour
// RL1: 525 even field: v falls one line later
// RL2: 525 odd field: v falls one line later
// RL3: 525: f toggles programmed lines after rollover
// RL4: 525 even field: f toggles one line later
// RL5: 525 odd field: f toggles one line later
// RL6: 625: v rises programmed lines after rollover
// RL7: 625 even field: v rises one line later
// RL8: 625 odd field: v rises one line later
// RL9: 625: v falls programmed lines, even delay
// RL10: 625 odd field: v falls one line later
// RL11: 625: f toggles programmed lines after rollover
// RL12: 625 even field: f toggles one line later
// RL13: 625 odd field: f toggles one line later
// RL14: host writes every sign bit as zero
// RL15: 525: v rises programmed lines, field delays
// RL16: line counter compared with counts plus delay
module vfb_line_timing (
    input  wire logic       I_MCLK,       // 50 mhz clock
    input  wire logic       I_SYS_RST,    // async reset, high
    input  wire logic       I_CLK_EN,     // clock enable
    input  wire logic       I_LINE_STRT,  // pulse at each line start
    input  wire logic       I_CNT_ROLL,   // pulse at counter rollover
    input  wire logic       I_FIELD_ODD,  // current field is odd
    input  wire logic       I_STD_625,    // 625-line standard
    input  wire logic       I_REG_WE,     // register write strobe
    input  wire logic       I_REG_RE,     // register read strobe
    input  wire logic [7:0] I_REG_ADDR,   // register subaddress
    input  wire logic [7:0] I_REG_WDATA,  // register write data
    output logic      [7:0] O_REG_RDATA,  // register read data
    output logic            O_V_BIT,      // vertical blanking bit
    output logic            O_F_BIT,      // field bit
    output logic      [5:0] O_LINE_CNT    // lines since rollover
);

    logic [47:0]       regs;
    vfb_pkg::vfb_std_s std525;
    vfb_pkg::vfb_std_s std625;
    vfb_pkg::vfb_std_s act;
    vfb_pkg::vfb_cnt_t cnt_q;
    vfb_pkg::vfb_cnt_t cnt_d;
    vfb_pkg::vfb_cnt_t vb_tgt;
    vfb_pkg::vfb_cnt_t ve_tgt;
    vfb_pkg::vfb_cnt_t ft_tgt;
    logic              odd_q;
    logic              std_q;
    logic              evt_q;
    logic              vb_hit;
    logic              ve_hit;
    logic              ft_hit;
    logic              v_d;
    logic              f_d;

    // register storage, reached over the serial interface port
    vfb_regfile vfb_regfile_inst (
        .i_clk   (I_MCLK),
        .i_rst   (I_SYS_RST),
        .i_en    (I_CLK_EN),
        .i_we    (I_REG_WE),
        .i_re    (I_REG_RE),
        .i_addr  (I_REG_ADDR),
        .i_wdata (I_REG_WDATA),
        .o_rdata (O_REG_RDATA),
        .o_regs  (regs)
    );

    // view the bytes as the two standard sets
    assign std525 = {regs[7:0], regs[15:8], regs[23:16]};
    assign std625 = {regs[31:24], regs[39:32], regs[47:40]};

    // programmed count plus the one-line delay of the field
    function automatic vfb_pkg::vfb_cnt_t target(
        input vfb_pkg::vfb_reg_s r,
        input logic              odd
    );
        logic dly;
        dly = odd ? r.odd_dly : r.even_dly;
        // sign bit is left out of the comparison
        return {1'b0, r.count} + 6'(dly); // RL14
    endfunction

    // active set and edge targets for the current field
    always_comb
    begin
        act    = std_q ? std625 : std525;
        vb_tgt = target(act.vbegin, odd_q); // RL6 RL7 RL8 RL15
        ve_tgt = target(act.vend, odd_q);   // RL1 RL2 RL9 RL10
        ft_tgt = target(act.ftog, odd_q);   // RL3 RL4 RL5 RL11 RL12 RL13
        vb_hit = evt_q && (cnt_q == vb_tgt);
        ve_hit = evt_q && (cnt_q == ve_tgt);
        ft_hit = evt_q && (cnt_q == ft_tgt);
    end

    // next line count, cleared at rollover, saturating
    always_comb
    begin
        cnt_d = cnt_q;
        if (I_CNT_ROLL)
            cnt_d = vfb_pkg::CNT_ZERO;
        else if (I_LINE_STRT && cnt_q != vfb_pkg::CNT_MAX)
            cnt_d = cnt_q + 6'h01;
    end

    // per-field line counter
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            cnt_q <= vfb_pkg::CNT_ZERO;
        else if (I_CLK_EN)
            cnt_q <= cnt_d; // RL16
    end

    // field parity and standard, taken at each line boundary
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            odd_q <= 1'b0;
            std_q <= 1'b0;
        end
        else if (I_CLK_EN && (I_CNT_ROLL || I_LINE_STRT))
        begin
            odd_q <= I_FIELD_ODD;
            std_q <= I_STD_625;
        end
    end

    // compare strobe, set on the same edge as each counter update
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            evt_q <= 1'b0;
        else if (I_CLK_EN)
            evt_q <= I_CNT_ROLL || I_LINE_STRT;
    end

    // v bit: rise wins when both edges land on one line
    always_comb
    begin
        v_d = O_V_BIT;
        if (vb_hit)
            v_d = 1'b1; // RL6 RL15
        else if (ve_hit)
            v_d = 1'b0; // RL1 RL2 RL9 RL10
    end

    // f bit toggles on its line
    assign f_d = ft_hit ? ~O_F_BIT : O_F_BIT; // RL3 RL11

    // output flops
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            O_V_BIT    <= 1'b0;
            O_F_BIT    <= 1'b0;
            O_LINE_CNT <= vfb_pkg::CNT_ZERO;
        end
        else if (I_CLK_EN)
        begin
            O_V_BIT    <= v_d;
            O_F_BIT    <= f_d;
            O_LINE_CNT <= cnt_d;
        end
    end

    // checks, all on the system clock
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SYS_RST);

    a_cnt_rollover: assert property ( // RL16
        I_CLK_EN && I_CNT_ROLL |=> cnt_q == 6'h00 && O_LINE_CNT == 6'h00
    ) else $error("line counter not cleared at rollover");

    // 525-line edges
    a_n_vbegin_edge: assert property ( // RL15
        I_CLK_EN && evt_q && !std_q &&
        cnt_q == {1'b0, std525.vbegin.count} +
                 6'(odd_q ? std525.vbegin.odd_dly : std525.vbegin.even_dly)
        |=> O_V_BIT
    ) else $error("525 v bit did not rise on its line");

    a_n_vend_even: assert property ( // RL1
        I_CLK_EN && evt_q && !std_q && !odd_q && !vb_hit &&
        cnt_q == {1'b0, std525.vend.count} + 6'(std525.vend.even_dly)
        |=> !O_V_BIT
    ) else $error("525 even field v bit did not fall");

    a_n_vend_odd: assert property ( // RL2
        I_CLK_EN && evt_q && !std_q && odd_q && !vb_hit &&
        cnt_q == {1'b0, std525.vend.count} + 6'(std525.vend.odd_dly)
        |=> !O_V_BIT
    ) else $error("525 odd field v bit did not fall");

    a_n_ftog_even: assert property ( // RL3 RL4
        I_CLK_EN && evt_q && !std_q && !odd_q &&
        cnt_q == {1'b0, std525.ftog.count} + 6'(std525.ftog.even_dly)
        |=> O_F_BIT != $past(O_F_BIT)
    ) else $error("525 even field f bit did not toggle");

    a_n_ftog_odd: assert property ( // RL5
        I_CLK_EN && evt_q && !std_q && odd_q &&
        cnt_q == {1'b0, std525.ftog.count} + 6'(std525.ftog.odd_dly)
        |=> O_F_BIT != $past(O_F_BIT)
    ) else $error("525 odd field f bit did not toggle");

    // 625-line edges
    a_p_vbegin_even: assert property ( // RL6 RL7
        I_CLK_EN && evt_q && std_q && !odd_q &&
        cnt_q == {1'b0, std625.vbegin.count} + 6'(std625.vbegin.even_dly)
        |=> O_V_BIT
    ) else $error("625 even field v bit did not rise");

    a_p_vbegin_odd: assert property ( // RL8
        I_CLK_EN && evt_q && std_q && odd_q &&
        cnt_q == {1'b0, std625.vbegin.count} + 6'(std625.vbegin.odd_dly)
        |=> O_V_BIT
    ) else $error("625 odd field v bit did not rise");

    a_p_vend_even: assert property ( // RL9
        I_CLK_EN && evt_q && std_q && !odd_q && !vb_hit &&
        cnt_q == {1'b0, std625.vend.count} + 6'(std625.vend.even_dly)
        |=> !O_V_BIT
    ) else $error("625 even field v bit did not fall");

    a_p_vend_odd: assert property ( // RL10
        I_CLK_EN && evt_q && std_q && odd_q && !vb_hit &&
        cnt_q == {1'b0, std625.vend.count} + 6'(std625.vend.odd_dly)
        |=> !O_V_BIT
    ) else $error("625 odd field v bit did not fall");

    a_p_ftog_even: assert property ( // RL11 RL12
        I_CLK_EN && evt_q && std_q && !odd_q &&
        cnt_q == {1'b0, std625.ftog.count} + 6'(std625.ftog.even_dly)
        |=> O_F_BIT != $past(O_F_BIT)
    ) else $error("625 even field f bit did not toggle");

    a_p_ftog_odd: assert property ( // RL13
        I_CLK_EN && evt_q && std_q && odd_q &&
        cnt_q == {1'b0, std625.ftog.count} + 6'(std625.ftog.odd_dly)
        |=> O_F_BIT != $past(O_F_BIT)
    ) else $error("625 odd field f bit did not toggle");

    // outputs move only on their own lines
    a_f_holds_off: assert property ( // RL16
        I_CLK_EN && !ft_hit |=> $stable(O_F_BIT)
    ) else $error("f bit changed off its line");

    a_v_holds_off: assert property ( // RL16
        I_CLK_EN && !vb_hit && !ve_hit |=> $stable(O_V_BIT)
    ) else $error("v bit changed off its lines");

    // counter, strobe and capture
    a_cnt_step: assert property ( // RL16
        I_CLK_EN && I_LINE_STRT && !I_CNT_ROLL &&
        cnt_q != vfb_pkg::CNT_MAX
        |=> cnt_q == $past(cnt_q) + 6'h01
    ) else $error("line counter did not step");

    a_cnt_output: assert property ( // RL16
        I_CLK_EN |=> O_LINE_CNT == cnt_q
    ) else $error("line count output differs from counter");

    a_evt_follows: assert property ( // RL16
        I_CLK_EN |=> evt_q == ($past(I_CNT_ROLL) || $past(I_LINE_STRT))
    ) else $error("compare strobe out of step");

    a_parity_capture: assert property ( // RL16
        I_CLK_EN && (I_CNT_ROLL || I_LINE_STRT)
        |=> odd_q == $past(I_FIELD_ODD) && std_q == $past(I_STD_625)
    ) else $error("field parity or standard not captured");

    // clock enable low freezes every state bit
    a_state_frozen: assert property ( // RL16
        !I_CLK_EN |=> $stable(cnt_q) && $stable(evt_q) &&
                      $stable(odd_q) && $stable(std_q) &&
                      $stable(O_V_BIT) && $stable(O_F_BIT) &&
                      $stable(regs) && $stable(O_REG_RDATA)
    ) else $error("state moved with clock enable low");

    // register port
    a_rdata_hold: assert property (
        !(I_CLK_EN && I_REG_RE) |=> $stable(O_REG_RDATA)
    ) else $error("read data moved without a read");

    a_unmapped_zero: assert property (
        I_CLK_EN && I_REG_RE &&
        (I_REG_ADDR < vfb_pkg::OFS_N_VBEGIN ||
         I_REG_ADDR > vfb_pkg::OFS_PAL_FIELD_TOGGLE_LINE)
        |=> O_REG_RDATA == 8'h00
    ) else $error("unmapped read did not return zero");

    // main scenarios
    c_v_rises: cover property (I_CLK_EN && !O_V_BIT ##1 O_V_BIT);
    c_n_ftog_odd: cover property (!std_q && odd_q && ft_hit);
    c_f_625: cover property (std_q && $changed(O_F_BIT));
    c_delay_odd: cover property (
        vb_hit && odd_q && std525.vbegin.odd_dly && !std_q);
    c_delay_even: cover property (
        ve_hit && !odd_q && std625.vend.even_dly && std_q);

endmodule

// *** hdl/vfb_pkg.sv ***
// package of the v/f bit line timing block: offsets, layout, resets
// assumes the register port decodes the byte subaddress directly
package vfb_pkg;

    // width of the per-field line counter, saturates at the top
    localparam int          CNT_W    = 6;
    localparam logic [5:0]  CNT_MAX  = 6'h3f;
    localparam logic [5:0]  CNT_ZERO = 6'h00;

    // register subaddresses
    localparam logic [7:0]  OFS_N_VBEGIN               = 8'he5;
    localparam logic [7:0]  OFS_N_VEND                 = 8'he6;
    localparam logic [7:0]  OFS_NTSC_FIELD_TOGGLE_LINE = 8'he7;
    localparam logic [7:0]  OFS_PAL_VBLANK_BEGIN_LINE  = 8'he8;
    localparam logic [7:0]  OFS_PAL_VBLANK_END_LINE    = 8'he9;
    localparam logic [7:0]  OFS_PAL_FIELD_TOGGLE_LINE  = 8'hea;
    localparam int          REG_NUM                    = 6;

    // field positions inside each register byte
    localparam int          POS_COUNT    = 0;
    localparam int          POS_SIGN     = 5;
    localparam int          POS_EVEN_DLY = 6;
    localparam int          POS_ODD_DLY  = 7;

    // values after reset
    localparam logic [7:0]  RST_N_VBEGIN = 8'h05;
    localparam logic [7:0]  RST_N_VEND   = 8'h04;
    localparam logic [7:0]  RST_N_FTOG   = 8'h03;
    localparam logic [7:0]  RST_P_VBEGIN = 8'h05;
    localparam logic [7:0]  RST_P_VEND   = 8'h14;
    localparam logic [7:0]  RST_P_FTOG   = 8'h03;

    // all resets, entry 0 in the low byte
    localparam logic [47:0] RST_ALL = {RST_P_FTOG, RST_P_VEND,
                                       RST_P_VBEGIN, RST_N_FTOG,
                                       RST_N_VEND, RST_N_VBEGIN};

    typedef logic [CNT_W-1:0] vfb_cnt_t;

    // one line-timing register
    typedef struct packed {
        logic       odd_dly;    // extra line in odd fields
        logic       even_dly;   // extra line in even fields
        logic       sign;       // written 0 by the host
        logic [4:0] count;      // lines after rollover
    } vfb_reg_s;

    // the three edges of one standard
    typedef struct packed {
        vfb_reg_s vbegin;
        vfb_reg_s vend;
        vfb_reg_s ftog;
    } vfb_std_s;

endpackage

// *** hdl/vfb_regfile.sv ***
// register storage for the six line-timing bytes, registered read data
// assumes one access per cycle from the serial interface slave
module vfb_regfile (
    input  wire logic        i_clk,     // system clock
    input  wire logic        i_rst,     // async reset, high
    input  wire logic        i_en,      // clock enable
    input  wire logic        i_we,      // write strobe
    input  wire logic        i_re,      // read strobe
    input  wire logic [7:0]  i_addr,    // byte subaddress
    input  wire logic [7:0]  i_wdata,   // write data
    output logic      [7:0]  o_rdata,   // read data, one cycle late
    output logic      [47:0] o_regs     // all contents, entry 0 low
);

    logic [7:0] idx;
    logic       hit;

    // index from subaddress, hit only inside the window
    assign idx = i_addr - vfb_pkg::OFS_N_VBEGIN;
    assign hit = (i_addr >= vfb_pkg::OFS_N_VBEGIN) &&
                 (i_addr <= vfb_pkg::OFS_PAL_FIELD_TOGGLE_LINE);

    // one storage byte per entry
    genvar g;
    generate
        for (g = 0; g < vfb_pkg::REG_NUM; g++)
        begin : g_ent
            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                    o_regs[g*8 +: 8] <= vfb_pkg::RST_ALL[g*8 +: 8];
                else if (i_en && i_we && hit && idx == 8'(g))
                    o_regs[g*8 +: 8] <= i_wdata;
            end
        end
    endgenerate

    // read port, unmapped addresses read zero
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_en && i_re)
            o_rdata <= hit ? o_regs[idx[2:0]*8 +: 8] : 8'h00;
    end

endmodule
